// ### include/cas_pkg.sv
// constants and carrier types for the counter array status and module mode block
//
// Operation
// - second counter rollover sets status bit 7; interrupts only if its enable set
// - first counter rollover sets status bit 3; interrupts only if its enable set
// - overflow flags set by hardware or software write, cleared only by software
// - module flags 0-2 at bits 0-2, 3-5 at bits 4-6; event sets, software clears
// - all eight sources ORed into one interrupt request to the core
// - mode bit 7 gates the module flag onto the interrupt request
// - mode bit 6 enables the comparator, needed by PWM, toggle and timer
// - mode bit 5 captures the counter on each rising pin edge
// - mode bit 4 captures on falling edges; both bits capture every transition
// - mode bit 3 lets a comparator match set the module flag
// - mode bit 2 inverts the module pin on every comparator match while the PWM field is 00
// - PWM field 01 gives 8-bit fixed-frequency PWM on the module pin
// - PWM field 10 gives 8-bit programmable-frequency PWM on the module pin
// - PWM field 11 gives 10- or 16-bit PWM chosen by width select bit
// - mode value zero, the reset value, means no capture, compare or PWM
// - counter control bit 5 gates that counter overflow flag onto the interrupt
// - counter control bit 2 selects 16-bit (0) or 10-bit (1) PWM
package cas_pkg;

  // ------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------
  localparam int NUM_MODULES    = 6;
  localparam int MODS_PER_CNT   = 3;

  // ------------------------------------------------------------
  // register addresses on the special function register bus
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CTL0      = 8'hA4;
  localparam logic [7:0] ADDR_STATUS    = 8'hA5;
  localparam logic [7:0] ADDR_CTL1      = 8'hBC;
  localparam logic [7:0] ADDR_MODE_BASE = 8'hD0;  // modes 0..5 at D0..D5
  localparam logic [7:0] ADDR_CCL_BASE  = 8'hE0;  // capture/compare low 0..5
  localparam logic [7:0] ADDR_CCH_BASE  = 8'hE8;  // capture/compare high 0..5

  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int STAT_SECOND_COUNTER_OVERFLOW_FLAG_BIT   = 7;
  localparam int STAT_FIRST_COUNTER_OVERFLOW_FLAG_BIT   = 3;
  localparam int STAT_LOW_GROUP  = 0;  // modules 0..2 at bits 0..2
  localparam int STAT_HIGH_GROUP = 4;  // modules 3..5 at bits 4..6
  localparam logic [7:0]  STATUS_RESET = 8'h00;
  localparam logic [7:0]  MODE_RESET   = 8'h00;
  localparam logic [7:0]  CTL_RESET    = 8'h00;
  localparam logic [15:0] CC_RESET     = 16'h0000;
  localparam logic [7:0]  CTL0_MASK    = 8'hF7;  // bit 3 reserved
  localparam logic [7:0]  CTL1_MASK    = 8'h77;  // bits 7 and 3 reserved
  localparam logic [1:0]  PWM_OFF      = 2'h0;
  localparam logic [1:0]  PWM_8_FIXED  = 2'h1;
  localparam logic [1:0]  PWM_8_PROG   = 2'h2;
  localparam logic [1:0]  PWM_WIDE     = 2'h3;

  // ------------------------------------------------------------
  // carrier types
  // ------------------------------------------------------------
  typedef struct packed {
    logic       irq_en;       // bit 7 module_irq_enable
    logic       comp_en;      // bit 6 comparator enable
    logic       cap_rise;     // bit 5 capture_rising_enable
    logic       cap_fall;     // bit 4 capture_falling_enable
    logic       match_en;     // bit 3 match sets flag
    logic       toggle_en;    // bit 2 toggle pin on match
    logic [1:0] pwm;          // bits 1..0 pwm mode
  } cas_mode_t;

  typedef struct packed {
    logic       run_all;      // bit 7 start both counters
    logic       run;          // bit 6 counter run
    logic       ovf_irq_en;   // bit 5 overflow_irq_enable
    logic       idle_stop;    // bit 4 stop in idle
    logic       rsvd;         // bit 3
    logic       pwm_width;    // bit 2 pwm_width_select, 1 = 10-bit
    logic [1:0] clk_sel;      // bits 1..0 counter clock source
  } cas_ctl_t;

  typedef struct packed {
    logic       wr;           // write strobe
    logic       rd;           // read strobe
    logic [7:0] addr;         // register address
    logic [7:0] wdata;        // write data
  } cas_sfr_req_t;

  typedef struct packed {
    logic        ovf;         // one-cycle rollover pulse
    logic [15:0] value;       // current counter value
  } cas_cnt_t;

endpackage

// ### design/cas_status_mode.sv
// status flags, module modes and pin behaviour of the two-counter array
`timescale 1ns/1ns
module cas_status_mode
  import cas_pkg::*;
(
  input  wire logic                     core_clk,   // system clock, 250 MHz
  input  wire logic                     rst_b,      // async reset, active low
  input  wire cas_sfr_req_t             sfr_req,    // register bus request
  output logic [7:0]                    sfr_rdata,  // registered read data
  input  wire cas_cnt_t                 cnt0,       // first counter value and rollover
  input  wire cas_cnt_t                 cnt1,       // second counter value and rollover
  output cas_ctl_t                      ctl0,       // first_counter_control to counter
  output cas_ctl_t                      ctl1,       // second_counter_control to counter
  output logic                          irq_req,    // combined interrupt, active high
  input  wire logic [NUM_MODULES-1:0]   pin_in,     // module_external_pin level in
  output logic [NUM_MODULES-1:0]        pin_out,    // module_external_pin drive value
  output logic [NUM_MODULES-1:0]        pin_oe_b    // low while the pin is driven
);

  // ------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------
  logic [7:0]              status;
  logic [7:0]              next_status;
  cas_mode_t               mode     [NUM_MODULES];
  logic [15:0]             cc       [NUM_MODULES];
  logic [NUM_MODULES-1:0]  mod_evt;          // one-cycle event per module
  logic [NUM_MODULES-1:0]  mod_irq;          // gated module flags
  logic [7:0]              next_rdata;

  // ------------------------------------------------------------
  // counter control registers
  // ------------------------------------------------------------
  // reserved bits are masked so they always read as zero
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl0 <= cas_ctl_t'(CTL_RESET);
      ctl1 <= cas_ctl_t'(CTL_RESET);
    end else if (sfr_req.wr) begin
      if (sfr_req.addr == ADDR_CTL0) begin
        ctl0 <= cas_ctl_t'(sfr_req.wdata & CTL0_MASK);
      end
      if (sfr_req.addr == ADDR_CTL1) begin
        ctl1 <= cas_ctl_t'(sfr_req.wdata & CTL1_MASK);
      end
    end
  end

  // ------------------------------------------------------------
  // status flags
  // ------------------------------------------------------------
  // software write lands first, hardware sets are ORed on top so a
  // rollover or event in the clearing cycle is never lost
  always_comb begin
    next_status = status;
    if (sfr_req.wr && sfr_req.addr == ADDR_STATUS) begin
      next_status = sfr_req.wdata;
    end
    if (cnt1.ovf) begin
      next_status[STAT_SECOND_COUNTER_OVERFLOW_FLAG_BIT] = 1'b1;
    end
    if (cnt0.ovf) begin
      next_status[STAT_FIRST_COUNTER_OVERFLOW_FLAG_BIT] = 1'b1;
    end
    for (int i = 0; i < MODS_PER_CNT; i++) begin
      if (mod_evt[i]) begin
        next_status[STAT_LOW_GROUP + i] = 1'b1;
      end
      if (mod_evt[MODS_PER_CNT + i]) begin
        next_status[STAT_HIGH_GROUP + i] = 1'b1;
      end
    end
  end

  // status register itself; only the path above ever clears a bit
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      status <= STATUS_RESET;
    end else begin
      status <= next_status;
    end
  end

  // ------------------------------------------------------------
  // combined interrupt request
  // ------------------------------------------------------------
  // registered, so the request follows a flag by one clock
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= (status[STAT_SECOND_COUNTER_OVERFLOW_FLAG_BIT] & ctl1.ovf_irq_en)
               | (status[STAT_FIRST_COUNTER_OVERFLOW_FLAG_BIT] & ctl0.ovf_irq_en)
               | (|mod_irq);
    end
  end

  // ------------------------------------------------------------
  // timer/compare modules
  // ------------------------------------------------------------
  // one copy per module; the three low modules share the first counter
  // and its control byte, the three high modules the second, so a width
  // select change moves every field-11 pwm output of that counter together
  for (genvar n = 0; n < NUM_MODULES; n++) begin : g_mod
    localparam logic [7:0] A_MODE = ADDR_MODE_BASE + 8'(n);
    localparam logic [7:0] A_CCL  = ADDR_CCL_BASE + 8'(n);
    localparam logic [7:0] A_CCH  = ADDR_CCH_BASE + 8'(n);
    localparam int         FBIT   = (n < MODS_PER_CNT) ? STAT_LOW_GROUP + n
                                                       : STAT_HIGH_GROUP + n - MODS_PER_CNT;

    logic [15:0] cnt_val;
    logic        wide10;
    logic        pin_q;
    logic        eq;
    logic        eq_q;
    logic        match;
    logic        capture;
    logic        pwm_high;

    // modules 0..2 follow the first counter, 3..5 the second
    assign cnt_val = (n < MODS_PER_CNT) ? cnt0.value : cnt1.value;
    assign wide10  = (n < MODS_PER_CNT) ? ctl0.pwm_width : ctl1.pwm_width;

    // mode register; zero after reset is the idle no-operation setting
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        mode[n] <= cas_mode_t'(MODE_RESET);
      end else if (sfr_req.wr && sfr_req.addr == A_MODE) begin
        mode[n] <= cas_mode_t'(sfr_req.wdata);
      end
    end

    // previous pin level for edge detection; pins are synchronous already
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        pin_q <= 1'b0;
        eq_q  <= 1'b0;
      end else begin
        pin_q <= pin_in[n];
        eq_q  <= eq;
      end
    end

    // capture on the enabled edge(s)
    assign capture = (mode[n].cap_rise & pin_in[n] & ~pin_q)
                   | (mode[n].cap_fall & ~pin_in[n] & pin_q);

    // comparator fires once per arrival at the compare value, since the
    // counter may rest on one value for many system clocks
    assign eq    = mode[n].comp_en && (cnt_val == cc[n]);
    assign match = eq & ~eq_q;

    // flag event: capture, or a match with the match bit set
    assign mod_evt[n] = capture | (match & mode[n].match_en);
    assign mod_irq[n] = status[FBIT] & mode[n].irq_en;

    // capture/compare pair; a capture overrides a same-cycle bus write
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        cc[n] <= CC_RESET;
      end else if (capture) begin
        cc[n] <= cnt_val;
      end else if (sfr_req.wr && sfr_req.addr == A_CCL) begin
        cc[n][7:0] <= sfr_req.wdata;
      end else if (sfr_req.wr && sfr_req.addr == A_CCH) begin
        cc[n][15:8] <= sfr_req.wdata;
      end
    end

    // pwm level: high once the counter reaches the compare value;
    // the programmable frequency comes from the counter's own period
    always_comb begin
      case (mode[n].pwm)
        PWM_8_FIXED: pwm_high = cnt_val[7:0] >= cc[n][7:0];
        PWM_8_PROG:  pwm_high = cnt_val[7:0] >= cc[n][7:0];
        PWM_WIDE: begin
          if (wide10) begin
            pwm_high = cnt_val[9:0] >= cc[n][9:0];
          end else begin
            pwm_high = cnt_val >= cc[n];
          end
        end
        default:     pwm_high = 1'b0;
      endcase
    end

    // pin drive: pwm output, toggle on match, or released
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        pin_out[n]  <= 1'b0;
        pin_oe_b[n] <= 1'b1;
      end else begin
        if (mode[n].pwm != PWM_OFF) begin
          // comparator off gives 0% duty
          pin_out[n]  <= pwm_high & mode[n].comp_en;
          pin_oe_b[n] <= 1'b0;
        end else if (mode[n].toggle_en && mode[n].comp_en) begin
          pin_oe_b[n] <= 1'b0;
          if (match) begin
            pin_out[n] <= ~pin_out[n];
          end
        end else begin
          pin_oe_b[n] <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  // unmapped addresses read zero; reads have no side effect
  always_comb begin
    next_rdata = 8'h00;
    case (sfr_req.addr)
      ADDR_STATUS: next_rdata = status;
      ADDR_CTL0:   next_rdata = ctl0;
      ADDR_CTL1:   next_rdata = ctl1;
      default: begin
        for (int i = 0; i < NUM_MODULES; i++) begin
          if (sfr_req.addr == ADDR_MODE_BASE + 8'(i)) begin
            next_rdata = mode[i];
          end
          if (sfr_req.addr == ADDR_CCL_BASE + 8'(i)) begin
            next_rdata = cc[i][7:0];
          end
          if (sfr_req.addr == ADDR_CCH_BASE + 8'(i)) begin
            next_rdata = cc[i][15:8];
          end
        end
      end
    endcase
  end

  // registered so the bus sees a clean output one clock after the address
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sfr_rdata <= 8'h00;
    end else begin
      sfr_rdata <= next_rdata;
    end
  end

endmodule

// ### dv/cas_status_mode_monitor.sv
// port assertions for the status and mode block
`timescale 1ns/1ns
module cas_status_mode_monitor
  import cas_pkg::*;
(
  input wire logic         core_clk,  // system clock
  input wire logic         rst_b,     // async reset, active low
  input wire cas_sfr_req_t sfr_req,   // register request
  input wire logic [7:0]   sfr_rdata, // read data
  input wire cas_cnt_t     cnt0,      // first counter
  input wire cas_cnt_t     cnt1,      // second counter
  input wire cas_ctl_t     ctl0,      // first counter control
  input wire cas_ctl_t     ctl1,      // second counter control
  input wire logic         irq_req,   // combined interrupt
  input wire logic [5:0]   pin_in,    // pin levels in
  input wire logic [5:0]   pin_out,   // pin drive value
  input wire logic [5:0]   pin_oe_b   // pin enable, low drives
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // a bus-quiet cycle after the rollover keeps the flag and enable intact
  property p_second_counter_overflow_flag_irq;
    cnt1.ovf && ctl1.ovf_irq_en ##1 !sfr_req.wr |-> ##1 irq_req;
  endproperty
  a_second_counter_overflow_flag_irq: assert property (p_second_counter_overflow_flag_irq)
    else $error("second rollover gave no irq");
  property p_first_counter_overflow_flag_irq;
    cnt0.ovf && ctl0.ovf_irq_en ##1 !sfr_req.wr |-> ##1 irq_req;
  endproperty
  a_first_counter_overflow_flag_irq: assert property (p_first_counter_overflow_flag_irq)
    else $error("first rollover gave no irq");
  // flags only drop through software, so irq falls only after a write
  property p_irq_fall;
    $fell(irq_req) |-> $past(sfr_req.wr, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("irq dropped without a write");
  property p_pin_hold;
    ((pin_out ^ $past(pin_out)) & pin_oe_b) == 6'h00;
  endproperty
  a_pin_hold: assert property (p_pin_hold)
    else $error("undriven pin changed value");
  property p_unmapped;
    sfr_req.addr == 8'hFF |=> sfr_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_rsvd;
    !ctl0.rsvd && !ctl1.rsvd && !ctl1.run_all;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved control bit set");
  property p_ctl0_wr;
    sfr_req.wr && sfr_req.addr == ADDR_CTL0 |=> ctl0 == ($past(sfr_req.wdata) & CTL0_MASK);
  endproperty
  a_ctl0_wr: assert property (p_ctl0_wr)
    else $error("control write lost");
  property p_ctl_hold;
    !sfr_req.wr |=> $stable(ctl0) && $stable(ctl1);
  endproperty
  a_ctl_hold: assert property (p_ctl_hold)
    else $error("control changed without write");
  property p_ctl1_rd;
    sfr_req.addr == ADDR_CTL1 && !sfr_req.wr |=> sfr_rdata == ctl1;
  endproperty
  a_ctl1_rd: assert property (p_ctl1_rd)
    else $error("control readback wrong");
  // main scenarios reached
  c_irq: cover property ($rose(irq_req));
  c_toggle: cover property (!pin_oe_b[0] && $changed(pin_out[0]));
  c_ovf: cover property (cnt1.ovf && ctl1.ovf_irq_en);
endmodule

// ### dv/cas_cpu_model.sv
// core-side model issuing register bus cycles
`timescale 1ns/1ns
module cas_cpu_model
  import cas_pkg::*;
(
  input  wire logic       core_clk,  // system clock
  output cas_sfr_req_t    sfr_req,   // register request
  input  wire logic [7:0] sfr_rdata  // read data
);
  initial sfr_req = '0;
  // write, entered at a falling edge; data inverted once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge core_clk);
    sfr_req.wr = 1'b0;
    sfr_req.wdata = ~d;
    // one idle edge so a following call never re-raises in this step
    @(negedge core_clk);
  endtask
  // read, data lands one edge after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfr_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge core_clk);
    d = sfr_rdata;
    sfr_req.rd = 1'b0;
    @(negedge core_clk);
  endtask
endmodule

// ### dv/cas_status_mode_tb_top.sv
// self-checking bench for the status and mode block
`timescale 1ns/1ns
module cas_status_mode_tb_top
  import cas_pkg::*;
;
  logic         core_clk, rst_b, irq_req;
  logic [7:0]   sfr_rdata, rd_val;
  cas_sfr_req_t sfr_req;
  cas_cnt_t     cnt0, cnt1;
  cas_ctl_t     ctl0, ctl1;
  logic [5:0]   pin_in, pin_out, pin_oe_b;
  int           fails, tests_run;
  // pwm table: mode, counter value, width select, expected level
  localparam logic [7:0]  PW_MODE [5] = '{8'h41, 8'h42, 8'h43, 8'h43, 8'h43};
  localparam logic [15:0] PW_VAL [5] = '{16'h0090, 16'h0090, 16'h0090, 16'h0490, 16'h0490};
  localparam logic [4:0]  PW_W = 5'b01000;
  localparam logic [4:0]  PW_EXP = 5'b10011;

  cas_status_mode u_dut (.core_clk(core_clk), .rst_b(rst_b), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .cnt0(cnt0), .cnt1(cnt1), .ctl0(ctl0), .ctl1(ctl1),
    .irq_req(irq_req), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_b(pin_oe_b));
  cas_cpu_model u_cpu (.core_clk(core_clk), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp, input string what);
    chk8({7'h00, got}, {7'h00, exp}, what);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string what);
    u_cpu.rd(a, rd_val);
    chk8(rd_val, exp, what);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic set_cnt(input logic [15:0] v);
    cnt0.value = v;
    cnt1.value = v;
  endtask
  task automatic pulse(input int which);
    if (which == 1) cnt1.ovf = 1'b1;
    else cnt0.ovf = 1'b1;
    @(negedge core_clk);
    cnt0.ovf = 1'b0;
    cnt1.ovf = 1'b0;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // the whole run needs well under a thousand cycles
  initial begin
    #100000;
    fails++;
    final_report();
  end
  initial begin
    int bit_pos;
    rst_b = 1'b0;
    cnt0 = '0;
    cnt1 = '0;
    pin_in = '0;
    fails = 0;
    tests_run = 0;
    cyc(12);
    rst_b = 1'b1;
    cyc(1);
    for (int n = 0; n < NUM_MODULES; n++) rchk(ADDR_MODE_BASE + 8'(n), MODE_RESET, "mode");
    rchk(ADDR_STATUS, STATUS_RESET, "status reset");
    chk8({2'b00, pin_oe_b}, 8'h3F, "pins released");
    rchk(8'hFF, 8'h00, "unmapped");
    u_cpu.wr(ADDR_CTL1, 8'hFF);
    rchk(ADDR_CTL1, CTL1_MASK, "ctl1 reserved");
    $display("test reset done");
    u_cpu.wr(ADDR_CTL1, 8'h20);
    u_cpu.wr(ADDR_CTL0, 8'h00);
    pulse(1);
    cyc(1);
    chk1(irq_req, 1'b1, "second_counter_overflow_flag irq");
    pulse(0);
    rchk(ADDR_STATUS, 8'h88, "both ovf");
    u_cpu.wr(ADDR_STATUS, 8'h08);
    cyc(2);
    chk1(irq_req, 1'b0, "first_counter_overflow_flag gated");
    u_cpu.wr(ADDR_CTL0, 8'h20);
    pulse(0);
    cyc(2);
    chk1(irq_req, 1'b1, "first_counter_overflow_flag irq");
    fork
      u_cpu.wr(ADDR_STATUS, 8'h00);
      pulse(1);
    join
    rchk(ADDR_STATUS, 8'h80, "set wins");
    u_cpu.wr(ADDR_STATUS, 8'h08);
    cyc(20);
    rchk(ADDR_STATUS, 8'h08, "sw set kept");
    u_cpu.wr(ADDR_STATUS, 8'h00);
    $display("test overflow done");
    for (int n = 0; n < NUM_MODULES; n++) begin
      bit_pos = (n < 3) ? n : n + 1;
      u_cpu.wr(ADDR_MODE_BASE + 8'(n), 8'hB0);
      set_cnt(16'h1200 + 16'(n));
      pin_in[n] = 1'b1;
      cyc(2);
      chk1(irq_req, 1'b1, "capture irq");
      rchk(ADDR_STATUS, 8'h01 << bit_pos, "capture flag");
      rchk(ADDR_CCL_BASE + 8'(n), 8'(n), "cc low");
      rchk(ADDR_CCH_BASE + 8'(n), 8'h12, "cc high");
      set_cnt(16'h3400);
      pin_in[n] = 1'b0;
      cyc(1);
      rchk(ADDR_CCH_BASE + 8'(n), 8'h34, "fall capture");
      u_cpu.wr(ADDR_STATUS, 8'h00);
      u_cpu.wr(ADDR_MODE_BASE + 8'(n), 8'h00);
    end
    u_cpu.wr(ADDR_MODE_BASE, 8'h20);
    set_cnt(16'h5600);
    pin_in[0] = 1'b1;
    cyc(2);
    chk1(irq_req, 1'b0, "flag gated");
    set_cnt(16'h7800);
    pin_in[0] = 1'b0;
    cyc(1);
    rchk(ADDR_CCH_BASE, 8'h56, "rising only");
    $display("test capture done");
    u_cpu.wr(ADDR_STATUS, 8'h00);
    u_cpu.wr(ADDR_CCL_BASE, 8'h10);
    u_cpu.wr(ADDR_CCH_BASE, 8'h00);
    u_cpu.wr(ADDR_MODE_BASE, 8'h0C);
    set_cnt(16'h0010);
    cyc(2);
    rchk(ADDR_STATUS, 8'h00, "comparator off");
    set_cnt(16'h000F);
    u_cpu.wr(ADDR_MODE_BASE, 8'h4C);
    set_cnt(16'h0010);
    cyc(3);
    chk1(pin_out[0], 1'b1, "toggle");
    chk1(pin_oe_b[0], 1'b0, "toggle drive");
    rchk(ADDR_STATUS, 8'h01, "timer flag");
    u_cpu.wr(ADDR_MODE_BASE, 8'h00);
    cyc(2);
    chk1(pin_oe_b[0], 1'b1, "no-op release");
    $display("test match done");
    u_cpu.wr(ADDR_CCL_BASE + 8'h03, 8'h80);
    u_cpu.wr(ADDR_CCH_BASE + 8'h03, 8'h01);
    // software sets width select with field 11 for the 10-bit row
    for (int i = 0; i < 5; i++) begin
      u_cpu.wr(ADDR_CTL1, {5'h00, PW_W[i], 2'h0});
      u_cpu.wr(ADDR_MODE_BASE + 8'h03, PW_MODE[i]);
      set_cnt(PW_VAL[i]);
      cyc(2);
      chk1(pin_out[3], PW_EXP[i], "pwm level");
      chk1(pin_oe_b[3], 1'b0, "pwm drive");
    end
    $display("test pwm done");
    final_report();
  end
endmodule

bind cas_status_mode cas_status_mode_monitor u_mon (.core_clk(core_clk), .rst_b(rst_b),
  .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .cnt0(cnt0), .cnt1(cnt1), .ctl0(ctl0),
  .ctl1(ctl1), .irq_req(irq_req), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_b(pin_oe_b));
